/* File: i2c_burst_host.sv */
// bus master model: start, stop, byte out, byte in
// assumes a pull-up resolves the data line outside this model
`timescale 1ns/100ps
module i2c_burst_host (
    input  wire logic clk_i,    // system clock
    input  wire logic sda_i,    // resolved data line
    output logic      scl_o,    // bus clock, still and high when idle
    output logic      sda_oe_o  // pulls data low
);
    initial begin
        scl_o    = 1'b1;
        sda_oe_o = 1'b0;
    end
    task automatic quarter();
        repeat (4) @(posedge clk_i);
    endtask
    // data only moves while the clock is low
    task automatic bit_io(input logic b, output logic r);
        sda_oe_o <= !b;
        quarter();
        scl_o <= 1'b1;
        quarter();
        r = sda_i;
        quarter();
        scl_o <= 1'b0;
        quarter();
    endtask
    task automatic start();
        sda_oe_o <= 1'b0;
        quarter();
        scl_o <= 1'b1;
        quarter();
        sda_oe_o <= 1'b1;
        quarter();
        scl_o <= 1'b0;
        quarter();
    endtask
    task automatic stop();
        sda_oe_o <= 1'b1;
        quarter();
        scl_o <= 1'b1;
        quarter();
        sda_oe_o <= 1'b0;
        quarter();
    endtask
    task automatic put(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task automatic get(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(!ack, r);
    endtask
endmodule

/* File: i2c_burst_pkg.sv */
// constants, types and helpers for the two-wire register access slave
// assumes a 100 MHz system clock and a register map outside this block
package i2c_burst_pkg;

    localparam int          REG_AW         = 7;
    localparam int          DATA_W         = 16;
    localparam int          NUM_PORTS      = 20;
    localparam logic [3:0]  BUS_ADDR_FIXED = 4'h7;
    localparam logic [6:0]  LAST_REG       = 7'h7f;
    // data register bases of port 0; the register map must agree
    localparam logic [6:0]  DAC_DATA_BASE  = 7'h60;
    localparam logic [6:0]  ADC_DATA_BASE  = 7'h40;
    localparam logic [2:0]  BIT_LAST       = 3'h7;
    localparam logic [1:0]  STRAP_SETTLE   = 2'h3;
    localparam int          INDEX_FLAG_BIT = 7;
    localparam int          CLK_HZ         = 100_000_000;
    localparam int          SCL_MAX_HZ     = 400_000;
    // system clocks per fastest bus clock period
    localparam int          SCL_MIN_CYC    = CLK_HZ / SCL_MAX_HZ;

    // what an address-select pin is tied to, as reported by its pad sensor
    typedef enum logic [1:0] {
        tie_ground,
        tie_supply,
        tie_data_line,
        tie_clock_line
    } strap_e;

    typedef struct packed {
        logic [REG_AW-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } reg_req_s;

    typedef struct packed {
        logic [DATA_W-1:0] rdata;
        logic              used;
        logic              read_only;
    } reg_rsp_s;

    // eight distinct low address bits from the two strap codes
    function automatic logic [2:0] strap_decode(input strap_e hi,
                                                input strap_e lo);
        logic [3:0] code;
        code = {hi, lo};
        strap_decode = {code[3] ^ code[2], code[1], code[0]};
    endfunction

endpackage

/* File: i2c_burst_slave.sv */
// two-wire bus slave giving the host burst access to 16-bit registers
// assumes a register map answering combinationally on the request address
// and bus pins with an external open-drain resolution
`timescale 1ns/100ps

// Behaviour
// - answer bus address 0111 plus strap bits
// - two four-way straps give eight addresses
// - bus clock up to fast-mode rate
// - no register change before word complete
// - pointer advances after every full word
// - plain step stops at the last register
// - index kept across stop and new start
// - unused addresses ignore writes, read zero
// - writes to read-only registers discarded
// - next register every further two bytes
// - two step modes, plain after reset
// - contextual write skips non-output ports
// - contextual step wraps to lowest port
// - contextual only for converter data bursts
module i2c_burst_slave
    import i2c_burst_pkg::*;
#(
    parameter int              PORTS   = NUM_PORTS,
    parameter logic [6:0]      TOP_REG = LAST_REG
) (
    input  wire logic          clk_i,                  // system clock
    input  wire logic          rst_n_i,                // async reset, low
    input  wire logic          scl_i,                  // bus clock pin
    input  wire logic          sda_i,                  // bus data pin in
    output logic               sda_o,                  // bus data out
    output logic               sda_oe_o,               // pulls data low
    input  wire strap_e        addr_select_pin_low_i,  // low strap code
    input  wire strap_e        addr_select_pin_high_i, // high strap code
    input  wire logic          contextual_mode_i,      // 1 = contextual
    input  wire logic [PORTS-1:0] dac_port_mask_i,     // output ports
    input  wire logic [PORTS-1:0] adc_port_mask_i,     // input ports
    output reg_req_s           reg_req_o,              // map request
    input  wire reg_rsp_s      reg_rsp_i               // map answer
);

    typedef enum logic [3:0] {
        st_idle,
        st_addr,
        st_addr_ack,
        st_index,
        st_index_ack,
        st_wbyte,
        st_wbyte_ack,
        st_rbyte,
        st_rbyte_ack
    } state_e;

    state_e            state;
    logic              scl_meta;
    logic              scl_sync;
    logic              scl_prev;
    logic              sda_meta;
    logic              sda_sync;
    logic              sda_prev;
    strap_e            lo_meta;
    strap_e            lo_sync;
    strap_e            hi_meta;
    strap_e            hi_sync;
    logic [1:0]        settle;
    logic [2:0]        own_low;
    logic [7:0]        shift;
    logic [7:0]        tx;
    logic [2:0]        bit_cnt;
    logic              got_byte;
    logic              rw;
    logic              low_byte;
    logic              host_ack;
    logic [7:0]        hi_byte;
    logic [DATA_W-1:0] word;
    logic [REG_AW-1:0] ptr;
    logic              ctx_mode;
    logic              commit;
    logic              load_word;
    logic              scl_rise;
    logic              scl_fall;
    logic              start_cond;
    logic              stop_cond;
    logic [DATA_W-1:0] read_val;
    logic [REG_AW-1:0] next_ptr;

    // oversampling fast-mode bus
    // the bus clock is sampled, at least SCL_MIN_CYC system clocks a period
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scl_meta <= 1'b1;
            scl_sync <= 1'b1;
            scl_prev <= 1'b1;
            sda_meta <= 1'b1;
            sda_sync <= 1'b1;
            sda_prev <= 1'b1;
        end else begin
            scl_meta <= scl_i;
            scl_sync <= scl_meta;
            scl_prev <= scl_sync;
            sda_meta <= sda_i;
            sda_sync <= sda_meta;
            sda_prev <= sda_sync;
        end
    end

    assign scl_rise   = scl_sync & ~scl_prev;
    assign scl_fall   = ~scl_sync & scl_prev;
    assign start_cond = scl_sync & scl_prev & sda_prev & ~sda_sync;
    assign stop_cond  = scl_sync & scl_prev & ~sda_prev & sda_sync;

    // strap decode
    // straps are caught once after release, so a live bus cannot move them
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lo_meta <= tie_ground;
            lo_sync <= tie_ground;
            hi_meta <= tie_ground;
            hi_sync <= tie_ground;
            settle  <= 2'h0;
            own_low <= 3'h0;
        end else begin
            lo_meta <= addr_select_pin_low_i;
            lo_sync <= lo_meta;
            hi_meta <= addr_select_pin_high_i;
            hi_sync <= hi_meta;
            if (settle != STRAP_SETTLE) begin
                settle <= settle + 2'h1;
                if (settle == STRAP_SETTLE - 2'h1) begin
                    own_low <= strap_decode(hi_sync, lo_sync);
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctx_mode <= 1'b0;
        end else begin
            ctx_mode <= contextual_mode_i;
        end
    end

    function automatic logic [REG_AW-1:0] ctx_step(
        input logic [REG_AW-1:0] cur,
        input logic [REG_AW-1:0] base,
        input logic [PORTS-1:0]  mask,
        input logic              plain_ok,
        input logic [REG_AW-1:0] plain
    );
        logic [REG_AW-1:0] off;
        logic              hit;
        logic              got_above;
        logic              got_low;
        logic [REG_AW-1:0] above;
        logic [REG_AW-1:0] lowest;
        off       = cur - base;
        hit       = 1'b0;
        got_above = 1'b0;
        got_low   = 1'b0;
        above     = '0;
        lowest    = '0;
        for (int i = 0; i < PORTS; i++) begin
            if (mask[i] && off == REG_AW'(i)) begin
                hit = 1'b1;
            end
            if (mask[i] && !got_low) begin
                got_low = 1'b1;
                lowest  = REG_AW'(i);
            end
            if (mask[i] && !got_above && REG_AW'(i) > off) begin
                got_above = 1'b1;
                above     = REG_AW'(i);
            end
        end
        if (!plain_ok || !hit) begin
            ctx_step = plain;
        end else if (got_above) begin
            ctx_step = base + above;
        end else begin
            ctx_step = base + lowest;
        end
    endfunction

    always_comb begin
        logic [REG_AW-1:0] plain;
        plain = ptr;
        if (ptr != TOP_REG) begin
            plain = ptr + REG_AW'(1);
        end
        if (rw) begin
            next_ptr = ctx_step(ptr, ADC_DATA_BASE, adc_port_mask_i,
                                ctx_mode, plain);
        end else begin
            next_ptr = ctx_step(ptr, DAC_DATA_BASE, dac_port_mask_i,
                                ctx_mode, plain);
        end
    end

    assign read_val = reg_rsp_i.used ? reg_rsp_i.rdata : '0;

    // bus protocol; every byte ends on a falling bus clock edge
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state     <= st_idle;
            shift     <= 8'h00;
            tx        <= 8'h00;
            bit_cnt   <= 3'h0;
            got_byte  <= 1'b0;
            rw        <= 1'b0;
            low_byte  <= 1'b0;
            host_ack  <= 1'b0;
            hi_byte   <= 8'h00;
            word      <= '0;
            ptr       <= '0;
            sda_oe_o  <= 1'b0;
            commit    <= 1'b0;
            load_word <= 1'b0;
        end else begin
            commit    <= 1'b0;
            load_word <= 1'b0;
            if (start_cond) begin
                state    <= st_addr;
                bit_cnt  <= 3'h0;
                got_byte <= 1'b0;
                sda_oe_o <= 1'b0;
            end else if (stop_cond) begin
                state    <= st_idle;
                sda_oe_o <= 1'b0;
            end else begin
                case (state)
                    st_addr, st_index, st_wbyte: begin
                        if (scl_rise) begin
                            shift   <= {shift[6:0], sda_sync};
                            bit_cnt <= bit_cnt + 3'h1;
                            if (bit_cnt == BIT_LAST) begin
                                got_byte <= 1'b1;
                            end
                        end else if (scl_fall && got_byte) begin
                            got_byte <= 1'b0;
                            if (state == st_addr) begin
                                if (shift[7:1] == {BUS_ADDR_FIXED, own_low})
                                begin
                                    rw       <= shift[0];
                                    low_byte <= 1'b0;
                                    sda_oe_o <= 1'b1;
                                    state    <= st_addr_ack;
                                end else begin
                                    state <= st_idle;
                                end
                            end else if (state == st_index) begin
                                if (!shift[INDEX_FLAG_BIT]) begin
                                    ptr      <= shift[6:0];
                                    sda_oe_o <= 1'b1;
                                    state    <= st_index_ack;
                                end else begin
                                    state <= st_idle;
                                end
                            end else begin
                                sda_oe_o <= 1'b1;
                                state    <= st_wbyte_ack;
                                if (!low_byte) begin
                                    hi_byte  <= shift;
                                    low_byte <= 1'b1;
                                end else begin
                                    commit   <= 1'b1;
                                    word     <= {hi_byte, shift};
                                    ptr      <= next_ptr;
                                    low_byte <= 1'b0;
                                end
                            end
                        end
                    end
                    st_addr_ack, st_index_ack, st_wbyte_ack: begin
                        if (scl_fall) begin
                            bit_cnt <= 3'h0;
                            if (state == st_addr_ack && rw) begin
                                load_word <= 1'b1;
                                word      <= read_val;
                                tx        <= read_val[15:8];
                                sda_oe_o  <= ~read_val[15];
                                state     <= st_rbyte;
                            end else begin
                                sda_oe_o <= 1'b0;
                                state    <= (state == st_addr_ack)
                                            ? st_index : st_wbyte;
                            end
                        end
                    end
                    st_rbyte: begin
                        if (scl_rise) begin
                            bit_cnt <= bit_cnt + 3'h1;
                            if (bit_cnt == BIT_LAST) begin
                                got_byte <= 1'b1;
                            end
                        end else if (scl_fall) begin
                            if (got_byte) begin
                                got_byte <= 1'b0;
                                sda_oe_o <= 1'b0;
                                state    <= st_rbyte_ack;
                            end else begin
                                tx       <= {tx[6:0], 1'b0};
                                sda_oe_o <= ~tx[6];
                            end
                        end
                    end
                    st_rbyte_ack: begin
                        if (scl_rise) begin
                            host_ack <= ~sda_sync;
                            if (low_byte) begin
                                ptr <= next_ptr;
                            end
                        end else if (scl_fall) begin
                            bit_cnt <= 3'h0;
                            if (host_ack) begin
                                state <= st_rbyte;
                                if (low_byte) begin
                                    low_byte  <= 1'b0;
                                    load_word <= 1'b1;
                                    word      <= read_val;
                                    tx        <= read_val[15:8];
                                    sda_oe_o  <= ~read_val[15];
                                end else begin
                                    low_byte <= 1'b1;
                                    tx       <= word[7:0];
                                    sda_oe_o <= ~word[7];
                                end
                            end else begin
                                state <= st_idle;
                            end
                        end
                    end
                    default: begin
                        sda_oe_o <= 1'b0;
                        got_byte <= 1'b0;
                        state    <= st_idle;
                    end
                endcase
            end
        end
    end

    // map request; address trails the pointer by one clock
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sda_o     <= 1'b0;
            reg_req_o <= '0;
        end else begin
            sda_o           <= 1'b0;
            // a commit holds the address one clock more, so the write
            // pulse lands on the register it was checked against
            if (!commit) begin
                reg_req_o.addr <= ptr;
            end
            reg_req_o.rd    <= load_word;
            reg_req_o.wdata <= word;
            reg_req_o.wr    <= commit && reg_rsp_i.used
                               && !reg_rsp_i.read_only;
        end
    end

endmodule

/* File: i2c_burst_slave_properties.sv */
// port-level checks for the two-wire register slave
// bound into every slave instance; one clock domain only
`timescale 1ns/100ps
module i2c_burst_slave_properties
    import i2c_burst_pkg::*;
#(
    parameter logic [6:0] TOP_REG = LAST_REG
) (
    input  wire logic     clk_i,             // system clock
    input  wire logic     rst_n_i,           // async reset, low
    input  wire logic     scl_i,             // bus clock pin
    input  wire logic     sda_o,             // data out value
    input  wire logic     sda_oe_o,          // data pull enable
    input  wire logic     contextual_mode_i, // step mode
    input  wire reg_req_s reg_req_o,         // map request
    input  wire reg_rsp_s reg_rsp_i          // map answer
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_plain_commit;
        reg_req_o.wr && !contextual_mode_i;
    endsequence
    property p_open_drain;
        sda_o == 1'b0;
    endproperty
    // a data change under a high clock would read as start or stop
    property p_oe_scl_low;
        $changed(sda_oe_o) |-> !scl_i;
    endproperty
    property p_wr_used;
        reg_req_o.wr |-> reg_rsp_i.used;
    endproperty
    property p_wr_writable;
        reg_req_o.wr |-> !reg_rsp_i.read_only;
    endproperty
    property p_plain_step;
        s_plain_commit ##0 (reg_req_o.addr != TOP_REG)
            |=> reg_req_o.addr == $past(reg_req_o.addr) + 7'h01;
    endproperty
    property p_saturate;
        s_plain_commit ##0 (reg_req_o.addr == TOP_REG)
            |=> reg_req_o.addr == TOP_REG;
    endproperty
    property p_wr_pulse;
        reg_req_o.wr |=> !reg_req_o.wr;
    endproperty
    property p_rd_pulse;
        reg_req_o.rd |=> !reg_req_o.rd;
    endproperty
    property p_addr_steady;
        reg_req_o.wr |-> $stable(reg_req_o.addr);
    endproperty

    a_open_drain: assert property (p_open_drain)
        else $error("data output driven high");
    a_oe_scl_low: assert property (p_oe_scl_low)
        else $error("data pull changed while clock high");
    a_wr_used: assert property (p_wr_used)
        else $error("write issued to unused address");
    a_wr_writable: assert property (p_wr_writable)
        else $error("write issued to read-only register");
    a_plain_step: assert property (p_plain_step)
        else $error("pointer did not step by one");
    a_saturate: assert property (p_saturate)
        else $error("pointer left the last register");
    a_wr_pulse: assert property (p_wr_pulse)
        else $error("write pulse longer than one cycle");
    a_rd_pulse: assert property (p_rd_pulse)
        else $error("read pulse longer than one cycle");
    a_addr_steady: assert property (p_addr_steady)
        else $error("target moved during commit");
endmodule

bind i2c_burst_slave i2c_burst_slave_properties #(.TOP_REG(TOP_REG)) u_props (
    .clk_i            (clk_i),
    .rst_n_i          (rst_n_i),
    .scl_i            (scl_i),
    .sda_o            (sda_o),
    .sda_oe_o         (sda_oe_o),
    .contextual_mode_i(contextual_mode_i),
    .reg_req_o        (reg_req_o),
    .reg_rsp_i        (reg_rsp_i)
);

/* File: testbench.sv */
// self-checking bench for the two-wire register slave
// register map modelled here; reads return a seeded pattern
`timescale 1ns/100ps
module testbench;
    import i2c_burst_pkg::*;
    localparam logic [6:0] RO_REG = 7'h00;
    localparam logic [6:0] NO_REG = 7'h05;
    localparam int         LIMIT  = 40000;
    logic                 clk = 1'b0;
    logic                 rst_n;
    logic                 scl;
    logic                 host_oe;
    logic                 dut_oe;
    logic                 mode;
    logic [NUM_PORTS-1:0] dac_mask;
    logic [NUM_PORTS-1:0] adc_mask;
    reg_req_s             req;
    reg_rsp_s             rsp;
    strap_e               strap_lo = tie_clock_line;
    strap_e               strap_hi = tie_supply;
    logic [15:0]          mem [128];
    logic [15:0]          n_wr = 16'h0000;
    int                   n_fail = 0;
    int                   n_tests = 0;
    int                   n_cyc = 0;
    wire                  sda = !(host_oe || dut_oe);
    wire  [6:0]           dev = {BUS_ADDR_FIXED, ^strap_hi, strap_lo};

    always #5 clk = ~clk;
    assign rsp = '{rdata: mem[req.addr], used: req.addr != NO_REG,
                   read_only: req.addr == RO_REG};

    i2c_burst_slave #(.PORTS(NUM_PORTS), .TOP_REG(LAST_REG)) DUT (
        .clk_i                 (clk),
        .rst_n_i               (rst_n),
        .scl_i                 (scl),
        .sda_i                 (sda),
        .sda_o                 (),
        .sda_oe_o              (dut_oe),
        .addr_select_pin_low_i (strap_lo),
        .addr_select_pin_high_i(strap_hi),
        .contextual_mode_i     (mode),
        .dac_port_mask_i       (dac_mask),
        .adc_port_mask_i       (adc_mask),
        .reg_req_o             (req),
        .reg_rsp_i             (rsp)
    );
    i2c_burst_host host (
        .clk_i   (clk),
        .sda_i   (sda),
        .scl_o   (scl),
        .sda_oe_o(host_oe)
    );

    always @(posedge clk) begin
        if (req.wr) begin
            mem[req.addr] <= req.wdata;
            n_wr          <= n_wr + 16'h0001;
        end
    end
    always @(posedge clk) begin
        n_cyc++;
        if (n_cyc == LIMIT) begin
            n_fail++;
            conclude();
        end
    end

    task automatic conclude();
        if (n_fail == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_burst(input logic [6:0] idx, input int n,
                            input logic [15:0] w [4]);
        logic        a;
        logic [15:0] old;
        old = mem[idx];
        host.start();
        host.put({dev, 1'b0}, a);
        host.put({1'b0, idx}, a);
        for (int i = 0; i < n; i++) begin
            host.put(w[i][15:8], a);
            if (i == 0) check(mem[idx], old);
            host.put(w[i][7:0], a);
        end
        host.stop();
    endtask
    task automatic rd_burst(input logic [6:0] idx, input int n,
                            output logic [15:0] r [4]);
        logic a;
        host.start();
        host.put({dev, 1'b0}, a);
        host.put({1'b0, idx}, a);
        host.stop();
        host.start();
        host.put({dev, 1'b1}, a);
        for (int i = 0; i < n; i++) begin
            host.get(1'b1, r[i][15:8]);
            host.get(i < n - 1, r[i][7:0]);
        end
        host.stop();
    endtask

    task automatic t_addr();
        logic a;
        host.start();
        host.put({BUS_ADDR_FIXED, 3'h0, 1'b0}, a);
        check({15'h0000, a}, 16'h0000);
        host.stop();
        host.start();
        host.put({dev, 1'b0}, a);
        check({15'h0000, a}, 16'h0001);
        host.put(8'h90, a);
        check({15'h0000, a}, 16'h0000);
        host.stop();
    endtask
    task automatic t_plain();
        logic [15:0] r [4];
        wr_burst(7'h10, 2, '{16'h1234, 16'h5678, 16'h0000, 16'h0000});
        check(mem[7'h11], 16'h5678);
        wr_burst(7'h7e, 3, '{16'h0aa1, 16'h0aa2, 16'h0aa3, 16'h0000});
        check(mem[7'h7e], 16'h0aa1);
        check(mem[7'h7f], 16'h0aa3);
        rd_burst(7'h10, 2, r);
        check(r[0], 16'h1234);
        check(r[1], 16'h5678);
    endtask
    task automatic t_refuse();
        logic [15:0] r [4];
        logic [15:0] n0;
        n0 = n_wr;
        wr_burst(RO_REG, 1, '{16'hbeef, 16'h0000, 16'h0000, 16'h0000});
        check(n_wr, n0);
        wr_burst(NO_REG, 1, '{16'hbeef, 16'h0000, 16'h0000, 16'h0000});
        check(n_wr, n0);
        rd_burst(NO_REG, 1, r);
        check(r[0], 16'h0000);
    endtask
    task automatic t_context();
        logic [15:0] r [4];
        @(posedge clk);
        mode     <= 1'b1;
        dac_mask <= 20'h0_000a;
        adc_mask <= 20'h0_0005;
        wr_burst(DAC_DATA_BASE + 7'h01, 3,
                 '{16'h0c01, 16'h0c03, 16'h0c11, 16'h0000});
        check(mem[DAC_DATA_BASE + 7'h03], 16'h0c03);
        check(mem[DAC_DATA_BASE + 7'h02], 16'ha562);
        check(mem[DAC_DATA_BASE + 7'h01], 16'h0c11);
        wr_burst(7'h20, 2, '{16'h0b01, 16'h0b02, 16'h0000, 16'h0000});
        check(mem[7'h21], 16'h0b02);
        rd_burst(ADC_DATA_BASE, 3, r);
        check(r[1], 16'ha542);
        check(r[2], 16'ha540);
        @(posedge clk);
        mode <= 1'b0;
    endtask
    task automatic t_strap();
        logic       a;
        logic [6:0] old_dev;
        old_dev = dev;
        rst_n    <= 1'b0;
        strap_lo <= tie_data_line;
        strap_hi <= tie_ground;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (20) @(posedge clk);
        host.start();
        host.put({old_dev, 1'b0}, a);
        check({15'h0000, a}, 16'h0000);
        host.stop();
        host.start();
        host.put({dev, 1'b0}, a);
        check({15'h0000, a}, 16'h0001);
        host.stop();
    endtask

    initial begin
        rst_n    = 1'b0;
        mode     = 1'b0;
        dac_mask = '0;
        adc_mask = '0;
        for (int i = 0; i < 128; i++)
            mem[i] = {8'ha5, 1'b0, 7'(i)};
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (20) @(posedge clk);
        t_addr();
        t_plain();
        t_refuse();
        t_context();
        t_strap();
        conclude();
    end
endmodule
